//--- hdl/cav_channel.sv
/*
 One capture/compare module: compare value, auto-reload value, comparator enable.
 Assumes at most one bus strobe per cycle from the decoder.
*/
`timescale 1ns/10ps
module cav_channel (
   input logic i_clk,
   input logic i_rst_n,
   input cav_pkg::cav_chan_ctrl_t i_ctrl,
   input logic [15:0] i_counter,
   output logic [15:0] o_compare,
   output logic [15:0] o_reload,
   output logic o_enable,
   output logic o_match
);

   cav_pkg::cav_chan_state_t st;
   cav_pkg::cav_chan_state_t next_st;

   // byte writes with their side effect on the enable
   always_comb begin
      next_st = st;
      if (i_ctrl.mode_wr && !i_ctrl.lock) begin
         next_st.enable = i_ctrl.mode_enable;
      end
      if (i_ctrl.wr_low) begin
         if (i_ctrl.sel_reload) begin
            next_st.reload[7:0] = i_ctrl.wdata;
         end else begin
            next_st.compare[7:0] = i_ctrl.wdata;
            if (!i_ctrl.lock) begin
               next_st.enable = 1'b0;
            end
         end
      end
      if (i_ctrl.wr_high) begin
         if (i_ctrl.sel_reload) begin
            next_st.reload[15:8] = i_ctrl.wdata;
         end else begin
            next_st.compare[15:8] = i_ctrl.wdata;
            if (!i_ctrl.lock) begin
               next_st.enable = 1'b1;
            end
         end
      end
      // compare only while enabled
      next_st.match = st.enable && (i_counter == st.compare);
   end

   // state register
   always_ff @(posedge i_clk) begin
      if (!i_rst_n) begin
         st.compare <= cav_pkg::WORD_RESET;
         st.reload <= cav_pkg::WORD_RESET;
         st.enable <= cav_pkg::ENABLE_RESET;
         st.match <= 1'b0;
      end else begin
         st <= next_st;
      end
   end

   assign o_compare = st.compare;
   assign o_reload = st.reload;
   assign o_enable = st.enable;
   assign o_match = st.match;

endmodule // cav_channel

//--- hdl/cav_counter.sv
/*
 The 16-bit counter with its high-byte snapshot.
 Assumes write strobes are already gated by the watchdog lock upstream.
*/
`timescale 1ns/10ps
module cav_counter (
   input logic i_clk,
   input logic i_rst_n,
   input logic i_tick,
   input logic i_wr_low,
   input logic i_wr_high,
   input logic i_rd_low,
   input logic [7:0] i_wdata,
   output logic [15:0] o_value,
   output logic [7:0] o_snapshot
);

   cav_pkg::cav_counter_state_t st;
   cav_pkg::cav_counter_state_t next_st;

   // count, software byte writes, snapshot on low-byte read
   always_comb begin
      next_st = st;
      if (i_tick) begin
         next_st.value = st.value + cav_pkg::COUNT_STEP;
      end
      if (i_wr_low) begin
         next_st.value[7:0] = i_wdata;
      end
      if (i_wr_high) begin
         next_st.value[15:8] = i_wdata;
      end
      if (i_rd_low) begin
         next_st.snapshot = st.value[15:8];
      end
   end

   // state register, snapshot held between low reads
   always_ff @(posedge i_clk) begin
      if (!i_rst_n) begin
         st.value <= cav_pkg::WORD_RESET;
         st.snapshot <= cav_pkg::BYTE_RESET;
      end else begin
         st <= next_st;
      end
   end

   assign o_value = st.value;
   assign o_snapshot = st.snapshot;

endmodule // cav_counter

//--- hdl/cav_pkg.sv
/*
 Shared constants and carrier types of the counter array value registers:
 special-function-register offsets, reset values, module count and state types.
 Assumes an 8-bit special-function-register bus from the processor core.
*/
package cav_pkg;

   // geometry
   localparam int NUM_MODULES = 6;
   localparam logic [2:0] WATCHDOG_MODULE = 3'h5;

   // counter byte offsets
   localparam logic [7:0] ADDR_COUNTER_LOW = 8'hF9;
   localparam logic [7:0] ADDR_COUNTER_HIGH = 8'hFA;

   // module byte offsets, index is the module number
   localparam logic [7:0] ADDR_MODULE_LOW [NUM_MODULES] =
      '{8'hFB, 8'hE9, 8'hEB, 8'hED, 8'hFD, 8'hD2};
   localparam logic [7:0] ADDR_MODULE_HIGH [NUM_MODULES] =
      '{8'hFC, 8'hEA, 8'hEC, 8'hEE, 8'hFE, 8'hD3};

   // values after reset, unmapped read value and count step
   localparam logic [7:0] BYTE_RESET = 8'h00;
   localparam logic [15:0] WORD_RESET = 16'h0000;
   localparam logic ENABLE_RESET = 1'b0;
   localparam logic [7:0] UNMAPPED_READ = 8'h00;
   localparam logic [15:0] COUNT_STEP = 16'h0001;

   // kind of bus access seen in a cycle
   typedef enum logic [2:0] {
      CAV_ACC_NONE = 3'b001,
      CAV_ACC_READ = 3'b010,
      CAV_ACC_WRITE = 3'b100
   } cav_access_t;

   // special-function-register request from the core
   typedef struct packed {
      logic [7:0] addr;
      logic wr;
      logic rd;
      logic [7:0] wdata;
   } cav_sfr_req_t;

   // per-module strobes from the decoder
   typedef struct packed {
      logic wr_low;
      logic wr_high;
      logic sel_reload;
      logic [7:0] wdata;
      logic mode_wr;
      logic mode_enable;
      logic lock;
   } cav_chan_ctrl_t;

   typedef struct packed {
      logic [15:0] compare;
      logic [15:0] reload;
      logic enable;
      logic match;
   } cav_chan_state_t;

   typedef struct packed {
      logic [15:0] value;
      logic [7:0] snapshot;
   } cav_counter_state_t;

   typedef struct packed {
      logic [7:0] rdata;
      logic hit;
      logic wd_module;
   } cav_top_state_t;

endpackage

//--- hdl/cav_value_regs.sv
/*
 Value registers of the counter array: counter bytes with snapshot, six module
 value bytes with auto-reload aliasing, comparator enable side effects.
 Assumes one special-function-register access per cycle from the core, read
 data returned one cycle after the strobe, and a count tick from the array's
 clock-source divider.
*/
// Overview of operation
// - counter split in low/high bytes, reset zero
// - high-byte read returns the snapshot register
// - snapshot loads only on a low-byte read
// - counter writes ignored while watchdog enabled
// - six modules, 16-bit value, two bytes, zero
// - select bit maps low address to reload
// - select bit maps high address to reload
// - low-byte write with select bit clear clears comparator enable, except module 5 while watchdog on
// - high-byte write with select bit clear sets comparator enable, except module 5 while watchdog on
// - enable bit gates counter compare per module
// - watchdog on: module 5 mode locked
`timescale 1ns/10ps
module cav_value_regs (
   input logic i_clk,
   input logic i_rst_n,
   input cav_pkg::cav_sfr_req_t i_sfr,
   input logic i_count_tick,
   input logic i_watchdog_enable,
   input logic i_auto_reload_select,
   input logic [5:0] i_mode_wr,
   input logic [5:0] i_mode_enable,
   output logic [7:0] o_sfr_rdata,
   output logic o_sfr_hit,
   output logic [15:0] o_counter,
   output logic [5:0] o_comparator_function_enable,
   output logic [5:0] o_match,
   output logic o_watchdog_module
);

   // top-level registered state
   cav_pkg::cav_top_state_t st;
   cav_pkg::cav_top_state_t next_st;

   // access kind of this cycle
   cav_pkg::cav_access_t acc_kind;

   // address decode
   logic hit_counter_low;
   logic hit_counter_high;
   logic [5:0] hit_module_low;
   logic [5:0] hit_module_high;
   logic addr_hit;

   // counter strobes
   logic cnt_wr_low;
   logic cnt_wr_high;
   logic cnt_rd_low;
   logic [15:0] counter_value;
   logic [7:0] counter_snapshot;

   // per-module values and controls
   cav_pkg::cav_chan_ctrl_t [5:0] chan_ctrl;
   logic [5:0][15:0] compare_value;
   logic [5:0][15:0] reload_value;
   logic [5:0] chan_enable;
   logic [5:0] chan_match;

   // read data of this cycle
   logic [7:0] read_byte;

   // classify the access; a write beats a read in the same cycle
   always_comb begin
      if (i_sfr.wr) begin
         acc_kind = cav_pkg::CAV_ACC_WRITE;
      end else if (i_sfr.rd) begin
         acc_kind = cav_pkg::CAV_ACC_READ;
      end else begin
         acc_kind = cav_pkg::CAV_ACC_NONE;
      end
   end

   // counter byte address matches
   assign hit_counter_low = (i_sfr.addr == cav_pkg::ADDR_COUNTER_LOW);
   assign hit_counter_high = (i_sfr.addr == cav_pkg::ADDR_COUNTER_HIGH);

   // whole map hit
   assign addr_hit = hit_counter_low
      || hit_counter_high
      || (|hit_module_low)
      || (|hit_module_high);

   // counter strobes, writes dropped while watchdog runs
   always_comb begin
      cnt_wr_low = 1'b0;
      cnt_wr_high = 1'b0;
      cnt_rd_low = 1'b0;
      case (acc_kind)
         cav_pkg::CAV_ACC_WRITE: begin
            cnt_wr_low = hit_counter_low && !i_watchdog_enable;
            cnt_wr_high = hit_counter_high && !i_watchdog_enable;
         end
         cav_pkg::CAV_ACC_READ: begin
            cnt_rd_low = hit_counter_low;
         end
         cav_pkg::CAV_ACC_NONE: begin
            cnt_rd_low = 1'b0;
         end
         default: begin
            cnt_rd_low = 1'b0;
         end
      endcase
   end

   // the counter and its snapshot
   cav_counter u_counter (
      .i_clk(i_clk),
      .i_rst_n(i_rst_n),
      .i_tick(i_count_tick),
      .i_wr_low(cnt_wr_low),
      .i_wr_high(cnt_wr_high),
      .i_rd_low(cnt_rd_low),
      .i_wdata(i_sfr.wdata),
      .o_value(counter_value),
      .o_snapshot(counter_snapshot)
   );

   // per-module decode, strobes and module instance
   genvar n;
   generate
      for (n = 0; n < cav_pkg::NUM_MODULES; n++) begin : g_module
         logic is_write;
         logic is_watchdog;

         assign hit_module_low[n] = (i_sfr.addr == cav_pkg::ADDR_MODULE_LOW[n]);
         assign hit_module_high[n] = (i_sfr.addr == cav_pkg::ADDR_MODULE_HIGH[n]);
         assign is_write = (acc_kind == cav_pkg::CAV_ACC_WRITE);
         assign is_watchdog = (n == int'(cav_pkg::WATCHDOG_MODULE));

         // strobes towards module n
         assign chan_ctrl[n].wr_low = is_write && hit_module_low[n];
         assign chan_ctrl[n].wr_high = is_write && hit_module_high[n];
         assign chan_ctrl[n].sel_reload = i_auto_reload_select;
         assign chan_ctrl[n].wdata = i_sfr.wdata;
         assign chan_ctrl[n].mode_wr = i_mode_wr[n];
         assign chan_ctrl[n].mode_enable = i_mode_enable[n];
         // module 5 belongs to the watchdog while it is on
         assign chan_ctrl[n].lock = is_watchdog && i_watchdog_enable;

         cav_channel u_channel (
            .i_clk(i_clk),
            .i_rst_n(i_rst_n),
            .i_ctrl(chan_ctrl[n]),
            .i_counter(counter_value),
            .o_compare(compare_value[n]),
            .o_reload(reload_value[n]),
            .o_enable(chan_enable[n]),
            .o_match(chan_match[n])
         );
      end
   endgenerate

   // read multiplexer; unmapped addresses read as zero
   always_comb begin
      read_byte = cav_pkg::UNMAPPED_READ;
      if (hit_counter_low) begin
         read_byte = counter_value[7:0];
      end
      if (hit_counter_high) begin
         read_byte = counter_snapshot;
      end
      for (int k = 0; k < cav_pkg::NUM_MODULES; k++) begin
         if (hit_module_low[k]) begin
            if (i_auto_reload_select) begin
               read_byte = reload_value[k][7:0];
            end else begin
               read_byte = compare_value[k][7:0];
            end
         end
         if (hit_module_high[k]) begin
            if (i_auto_reload_select) begin
               read_byte = reload_value[k][15:8];
            end else begin
               read_byte = compare_value[k][15:8];
            end
         end
      end
   end

   // bus answer and watchdog indication
   always_comb begin
      next_st = st;
      next_st.hit = 1'b0;
      next_st.wd_module = i_watchdog_enable;
      case (acc_kind)
         cav_pkg::CAV_ACC_READ: begin
            next_st.hit = addr_hit;
            next_st.rdata = read_byte;
         end
         cav_pkg::CAV_ACC_WRITE: begin
            next_st.hit = addr_hit;
         end
         cav_pkg::CAV_ACC_NONE: begin
            next_st.hit = 1'b0;
         end
         default: begin
            next_st.hit = 1'b0;
         end
      endcase
   end

   // state register
   always_ff @(posedge i_clk) begin
      if (!i_rst_n) begin
         st.rdata <= cav_pkg::BYTE_RESET;
         st.hit <= 1'b0;
         st.wd_module <= 1'b0;
      end else begin
         st <= next_st;
      end
   end

   // outputs, each from a flip-flop
   assign o_sfr_rdata = st.rdata;
   assign o_sfr_hit = st.hit;
   assign o_counter = counter_value;
   assign o_comparator_function_enable = chan_enable;
   assign o_match = chan_match;
   assign o_watchdog_module = st.wd_module;

endmodule // cav_value_regs

//--- sim/cav_value_regs_monitor.sv
/*
 Checker of the value registers, ports of cav_value_regs only.
 Assumes one clock and the synchronous active-low reset.
*/
`timescale 1ns/10ps
module cav_value_regs_monitor (
   input logic i_clk,
   input logic i_rst_n,
   input cav_pkg::cav_sfr_req_t i_sfr,
   input logic i_count_tick,
   input logic i_watchdog_enable,
   input logic i_auto_reload_select,
   input logic [5:0] i_mode_wr,
   input logic [5:0] i_mode_enable,
   input logic [7:0] o_sfr_rdata,
   input logic o_sfr_hit,
   input logic [15:0] o_counter,
   input logic [5:0] o_comparator_function_enable,
   input logic [5:0] o_match,
   input logic o_watchdog_module
);
   default clocking @(posedge i_clk); endclocking
   default disable iff (!i_rst_n);
   logic [7:0] snap_q;
   logic [7:0] l0;
   logic [7:0] h0;
   logic wr;
   assign l0 = cav_pkg::ADDR_MODULE_LOW[0];
   assign h0 = cav_pkg::ADDR_MODULE_HIGH[0];
   assign wr = i_sfr.wr && !i_watchdog_enable;
   // expected snapshot, taken at each low-byte read
   always_ff @(posedge i_clk) begin
      if (!i_rst_n) snap_q <= 8'h00;
      else if (i_sfr.rd && !i_sfr.wr && i_sfr.addr == 8'hF9) snap_q <= o_counter[15:8];
   end
   sequence s_rd_low;
      i_sfr.rd && !i_sfr.wr && i_sfr.addr == 8'hF9;
   endsequence
   sequence s_rd_high;
      i_sfr.rd && !i_sfr.wr && i_sfr.addr == 8'hFA;
   endsequence
   property p_rd_low;
      s_rd_low |=> o_sfr_hit && o_sfr_rdata == $past(o_counter[7:0]);
   endproperty
   a_rd_low: assert property (p_rd_low) else $error("low read wrong");
   property p_rd_high;
      s_rd_high |=> o_sfr_hit && o_sfr_rdata == $past(snap_q);
   endproperty
   a_rd_high: assert property (p_rd_high) else $error("high read wrong");
   property p_lock;
      i_watchdog_enable && i_sfr.wr && !i_count_tick
      && (i_sfr.addr == cav_pkg::ADDR_COUNTER_LOW || i_sfr.addr == cav_pkg::ADDR_COUNTER_HIGH)
      |=> $stable(o_counter);
   endproperty
   a_lock: assert property (p_lock) else $error("locked counter changed");
   property p_wr_high;
      wr && i_sfr.addr == 8'hFA |=> o_counter[15:8] == $past(i_sfr.wdata);
   endproperty
   a_wr_high: assert property (p_wr_high) else $error("high write lost");
   property p_low_clr;
      wr && !i_auto_reload_select && i_sfr.addr == l0 && !i_mode_wr[0]
      |=> !o_comparator_function_enable[0];
   endproperty
   a_low_clr: assert property (p_low_clr) else $error("enable not cleared");
   property p_high_set;
      wr && !i_auto_reload_select && i_sfr.addr == h0 && !i_mode_wr[0]
      |=> o_comparator_function_enable[0];
   endproperty
   a_high_set: assert property (p_high_set) else $error("enable not set");
   property p_reload_keep;
      i_sfr.wr && i_auto_reload_select && i_sfr.addr == l0 && !i_mode_wr[0]
      |=> $stable(o_comparator_function_enable[0]);
   endproperty
   a_reload_keep: assert property (p_reload_keep) else $error("reload write moved enable");
   property p_wd5;
      i_watchdog_enable |=> $stable(o_comparator_function_enable[5]);
   endproperty
   a_wd5: assert property (p_wd5) else $error("module 5 enable changed");
   // watchdog indication follows the enable one cycle later
   property p_wd_flag;
      1'b1 |=> o_watchdog_module == $past(i_watchdog_enable);
   endproperty
   a_wd_flag: assert property (p_wd_flag) else $error("watchdog flag wrong");
   property p_match_gate;
      !o_comparator_function_enable[0] |=> !o_match[0];
   endproperty
   a_match_gate: assert property (p_match_gate) else $error("match while disabled");
endmodule // cav_value_regs_monitor

bind cav_value_regs cav_value_regs_monitor u_mon (.i_clk, .i_rst_n, .i_sfr, .i_count_tick,
   .i_watchdog_enable, .i_auto_reload_select, .i_mode_wr, .i_mode_enable, .o_sfr_rdata,
   .o_sfr_hit, .o_counter, .o_comparator_function_enable, .o_match, .o_watchdog_module);

//--- sim/tb_top.sv
/*
 Directed testbench of the value registers over the byte bus.
 Assumes the monitor is bound to the same instance.
*/
`timescale 1ns/10ps
module tb_top;
   logic i_clk, i_rst_n, i_count_tick, i_watchdog_enable, i_auto_reload_select;
   cav_pkg::cav_sfr_req_t i_sfr;
   logic [5:0] i_mode_wr, i_mode_enable, o_comparator_function_enable, o_match;
   logic [7:0] o_sfr_rdata;
   logic [15:0] o_counter;
   logic o_sfr_hit, o_watchdog_module;
   int err_total = 0;
   int num_checks = 0;
   cav_value_regs uut (.i_clk, .i_rst_n, .i_sfr, .i_count_tick, .i_watchdog_enable,
      .i_auto_reload_select, .i_mode_wr, .i_mode_enable, .o_sfr_rdata, .o_sfr_hit,
      .o_counter, .o_comparator_function_enable, .o_match, .o_watchdog_module);
   // 200 MHz clock
   initial begin
      i_clk = 1'b0;
      forever #2.5 i_clk = ~i_clk;
   end
   task automatic chk(input logic [15:0] s, input logic [15:0] e);
      num_checks++;
      if (s !== e) begin
         err_total++;
         $display("[ERR] t=%0t seen=%h exp=%h", $time, s, e);
      end
   endtask
   // one bus access, sampled after the answer edge
   task automatic acc(input logic w, input logic [7:0] a, input logic [7:0] d);
      @(posedge i_clk);
      i_sfr <= '{a, w, !w, d};
      @(posedge i_clk);
      i_sfr.wr <= 1'b0;
      i_sfr.rd <= 1'b0;
      #1;
   endtask
   task automatic rdc(input logic [7:0] a, input logic [7:0] e);
      acc(1'b0, a, 8'h00);
      chk(16'(o_sfr_rdata), 16'(e));
   endtask
   task automatic tick(input int n);
      @(posedge i_clk);
      i_count_tick <= 1'b1;
      repeat (n) @(posedge i_clk);
      i_count_tick <= 1'b0;
      #1;
   endtask
   task automatic mode(input logic [5:0] m, input logic [5:0] v);
      @(posedge i_clk);
      i_mode_wr <= m;
      i_mode_enable <= v;
      @(posedge i_clk);
      i_mode_wr <= 6'h00;
      #1;
   endtask
   task automatic t_reset;
      #1;
      chk(o_counter, 16'h0000);
      for (int i = 0; i < 6; i++) begin
         rdc(cav_pkg::ADDR_MODULE_LOW[i], 8'h00);
         rdc(cav_pkg::ADDR_MODULE_HIGH[i], 8'h00);
      end
      rdc(8'h00, 8'h00);
      chk(16'(o_sfr_hit), 16'h0000);
   endtask
   task automatic t_counter;
      acc(1'b1, 8'hF9, 8'h34);
      chk(16'(o_sfr_hit), 16'h0001);
      acc(1'b1, 8'hFA, 8'h12);
      chk(o_counter, 16'h1234);
      tick(3);
      rdc(8'hF9, 8'h37);
      acc(1'b1, 8'hFA, 8'h56);
      chk(o_counter, 16'h5637);
      tick(2);
      rdc(8'hFA, 8'h12);
      rdc(8'hF9, 8'h39);
      rdc(8'hFA, 8'h56);
   endtask
   task automatic t_lock;
      mode(6'h20, 6'h20);
      @(posedge i_clk);
      i_watchdog_enable <= 1'b1;
      acc(1'b1, 8'hF9, 8'hAA);
      acc(1'b1, 8'hFA, 8'hBB);
      chk(16'(o_sfr_hit), 16'h0001);
      chk(o_counter, 16'h5639);
      mode(6'h20, 6'h00);
      acc(1'b1, 8'hD2, 8'h77);
      chk(16'(o_comparator_function_enable[5]), 16'h0001);
      chk(16'(o_watchdog_module), 16'h0001);
      @(posedge i_clk);
      i_watchdog_enable <= 1'b0;
      acc(1'b1, 8'hF9, 8'hAA);
      chk(o_counter, 16'h56AA);
      chk(16'(o_watchdog_module), 16'h0000);
   endtask
   task automatic t_modules;
      for (int i = 0; i < 5; i++) begin
         acc(1'b1, cav_pkg::ADDR_MODULE_HIGH[i], 8'h5F);
         chk(16'(o_comparator_function_enable[i]), 16'h0001);
         acc(1'b1, cav_pkg::ADDR_MODULE_LOW[i], 8'(8'h10 + i));
         chk(16'(o_comparator_function_enable[i]), 16'h0000);
         acc(1'b1, cav_pkg::ADDR_MODULE_HIGH[i], 8'(8'hA0 + i));
         chk(16'(o_comparator_function_enable[i]), 16'h0001);
         rdc(cav_pkg::ADDR_MODULE_LOW[i], 8'(8'h10 + i));
         rdc(cav_pkg::ADDR_MODULE_HIGH[i], 8'(8'hA0 + i));
      end
      @(posedge i_clk);
      i_auto_reload_select <= 1'b1;
      acc(1'b1, cav_pkg::ADDR_MODULE_LOW[0], 8'h3C);
      acc(1'b1, cav_pkg::ADDR_MODULE_HIGH[0], 8'hC3);
      rdc(cav_pkg::ADDR_MODULE_LOW[0], 8'h3C);
      rdc(cav_pkg::ADDR_MODULE_HIGH[0], 8'hC3);
      @(posedge i_clk);
      i_auto_reload_select <= 1'b0;
      rdc(cav_pkg::ADDR_MODULE_LOW[0], 8'h10);
      rdc(cav_pkg::ADDR_MODULE_HIGH[0], 8'hA0);
      acc(1'b1, 8'hF9, 8'h10);
      acc(1'b1, 8'hFA, 8'hA0);
      @(posedge i_clk);
      #1;
      chk(16'(o_match), 16'h0001);
      mode(6'h01, 6'h00);
      @(posedge i_clk);
      #1;
      chk(16'(o_match), 16'h0000);
   endtask
   task automatic tally_and_finish;
      $display("checks %0d errors %0d", num_checks, err_total);
      if (err_total == 0 && num_checks > 0)
         $display("Testbench passed");
      else
         $display("Testbench failed");
      $finish;
   endtask
   // main sequence
   initial begin
      i_rst_n = 1'b0;
      i_sfr = '0;
      i_count_tick = 1'b0;
      i_watchdog_enable = 1'b0;
      i_auto_reload_select = 1'b0;
      i_mode_wr = 6'h00;
      i_mode_enable = 6'h00;
      repeat (8) @(posedge i_clk);
      i_rst_n <= 1'b1;
      t_reset();
      t_counter();
      t_lock();
      t_modules();
      tally_and_finish();
   end
   // hang guard
   initial begin
      #20000;
      err_total++;
      tally_and_finish();
   end
endmodule // tb_top
